// ---- gp_board.sv ----
/*
  Board model for the pin port: resolves each pad from the port's drive,
  an external driver and the pulls; an undriven pad wanders.
  Assumes it shares the port clock.
*/
`default_nettype none

module gp_board
(
  input wire logic clk_i, // Port clock
  input wire logic [6:0] out_i, // Port output values
  input wire logic [6:0] oe_i, // Port output enables
  input wire logic [6:0] pu_i, // Pull-up enables
  input wire logic [6:0] pd_i, // Pull-down enables
  input wire logic [6:0] ext_en_i, // External driver active
  input wire logic [6:0] ext_val_i, // External driver level
  output logic [6:0] pin_o // Resolved pad level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] last_r; // Last resolved level

  ////////////////////////////////////////////////////////////////////
  // A floating pad shows the inverse of its last level, never a copy
  always_ff @(posedge clk_i)
    last_r <= pin_o;

  // Port drive wins, then the external driver, then pull-up, then pull-down
  always_comb
  begin
    for (int i = 0; i < 7; i++)
    begin
      if (oe_i[i]) pin_o[i] = out_i[i];
      else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
      else if (pu_i[i]) pin_o[i] = 1'b1;
      else if (pd_i[i]) pin_o[i] = 1'b0;
      else pin_o[i] = ~last_r[i];
    end
  end
endmodule

`default_nettype wire

// ---- gp_key_sense.sv ----
/*
  Keypad input sensing for one pin: edge, level or both, either polarity.
  Assumes a synchronous pin level; stop restricts sensing to low/falling.
*/
`default_nettype none

module gp_key_sense
(
  input wire logic clk_i, // Port clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic ce_i, // Clock enable
  input wire logic pin_i, // Pin level after input buffer
  input wire logic en_i, // Keypad pin enable
  input wire logic rise_i, // 1 = rising/high, 0 = falling/low
  input wire logic edge_en_i, // Sense edges
  input wire logic level_en_i, // Sense levels
  input wire logic stop_i, // Any stop mode
  output logic event_o // Registered event pulse
);

  logic prev_r, prev_nxt; // Last sampled level
  logic event_r, event_nxt; // Event flop
  logic pol; // Effective polarity

  ////////////////////////////////////////////////////////////////////////
  // Next event; stop modes force low/falling sensing
  always_comb
  begin
    pol = rise_i & ~stop_i;
    prev_nxt = pin_i;
    event_nxt = en_i & ((edge_en_i & (pol ? (pin_i & ~prev_r) : (~pin_i & prev_r)))
                | (level_en_i & (pin_i == pol)));
  end

  // Registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_r <= 1'b1;
      event_r <= 1'b0;
    end
    else if (ce_i)
    begin
      prev_r <= prev_nxt;
      event_r <= event_nxt;
    end
  end

  assign event_o = event_r;

endmodule

`default_nettype wire

// ---- gp_pin_cell.sv ----
/*
  One pin's buffer, pull and read-source logic; purely combinational.
  Assumes the pin level is synchronous to the port clock.
*/
`default_nettype none

module gp_pin_cell
(
  input wire gp_port_pkg::pin_ctrl_t ctrl_i, // Pin controls
  input wire logic per_out_i, // Peripheral output value
  input wire logic per_oe_i, // Peripheral output enable
  input wire logic pin_i, // Level on the pin
  output gp_port_pkg::pin_pad_t pad_o, // Pad controls
  output logic rd_o // Bit seen by a data register read
);

  logic drive_en; // Output enable before power gating
  logic pull_ok; // Pull allowed at all

  ////////////////////////////////////////////////////////////////////////
  // Buffers: analog beats digital function beats software
  always_comb
  begin
    if (ctrl_i.ana)
    begin
      drive_en = 1'b0;
    end
    else if (ctrl_i.dig)
    begin
      drive_en = per_oe_i;
    end
    else
    begin
      drive_en = ctrl_i.dir;
    end
    pad_o.oe = drive_en & ~ctrl_i.off;
    pad_o.out = ctrl_i.dig ? per_out_i : ctrl_i.data;
    pad_o.inbuf = ~ctrl_i.ana & ~ctrl_i.off;
    // Any output role, by software or peripheral, kills the pull
    pull_ok = ctrl_i.pull & ~ctrl_i.dir & ~(ctrl_i.dig & per_oe_i)
              & ~ctrl_i.ana & ~ctrl_i.off;
    pad_o.pu = pull_ok & ~ctrl_i.pd_sel;
    pad_o.pd = pull_ok & ctrl_i.pd_sel;
    // Direction alone picks the read source, even under a peripheral
    rd_o = ctrl_i.dir ? ctrl_i.data : (pin_i & pad_o.inbuf);
  end

endmodule

`default_nettype wire

// ---- gp_port.sv ----
/*
  General purpose pin port: five-pin port A and two-pin port B behind an
  Avalon-MM slave, with shared digital, analog, keypad, interrupt and
  debug-strap handling and stop-mode behaviour.
  Assumes pins, peripheral signals and stop inputs are synchronous to CLK_I.
*/
`include "gp_port_params.svh"
`default_nettype none

// Function
// - Seven pins: five-bit A, two-bit B
// - Direction enables driver and picks read source
// - Input direction: driver off, read pin
// - Input buffer on unless analog enabled
// - Digital function drives; direction still picks read
// - Analog kills buffers; input read gives zero
// - Analog wins over digital function
// - Functions override; all off after reset
// - Pull-up off for outputs or analog
// - Keypad edge/level sensing, stop low only
// - Pin zero interrupt request wakes retention stop
// - Pin four low at reset: debug
// - Pin four is output-only in GPIO
// - Deep stop clears registers, pins off
// - Retention stop keeps all pin state
// - Port A data bits 4:0, top zero
module gp_port
(
  input wire logic CLK_I, // Port clock, 125 MHz
  input wire logic CE_I, // Clock enable, freezes state when low
  input wire logic SYS_RST_I, // Synchronous reset, high
  input wire logic [5:0] AVS_ADDRESS_I, // Byte address
  input wire logic AVS_READ_I, // Read request
  input wire logic AVS_WRITE_I, // Write request
  input wire logic [31:0] AVS_WRITEDATA_I, // Write data
  input wire logic [3:0] AVS_BYTEENABLE_I, // Byte enables
  output logic [31:0] AVS_READDATA_O, // Read data, registered
  output logic AVS_WAITREQUEST_O, // Wait request
  input wire logic [`GP_NUM_PINS-1:0] PIN_I, // Pin levels
  output logic [`GP_NUM_PINS-1:0] PIN_O, // Pin output values
  output logic [`GP_NUM_PINS-1:0] PIN_OE_O, // Pin output enables
  output logic [`GP_NUM_PINS-1:0] PULLUP_O, // Pull-up enables
  output logic [`GP_NUM_PINS-1:0] PULLDN_O, // Pull-down enables
  output logic [`GP_NUM_PINS-1:0] INBUF_EN_O, // Input buffer enables
  input wire logic [`GP_NUM_PINS-1:0] PERIPH_OUT_I, // Peripheral outputs
  input wire logic [`GP_NUM_PINS-1:0] PERIPH_OE_I, // Peripheral output enables
  output logic [`GP_NUM_PINS-1:0] PERIPH_IN_O, // Buffered pin levels to peripherals
  input wire logic DEEP_STOP_I, // Deep stop mode, level
  input wire logic RETAIN_STOP_I, // Retention stop mode, level
  input wire logic DBG_OUT_I, // Debug data out
  input wire logic DBG_OE_I, // Debug drive enable
  output logic DBG_IN_O, // Debug data in
  output logic DBG_MODE_O, // Pin four owned by debug
  output logic IRQ_REQ_O, // Interrupt request, registered
  output logic [`GP_NUM_KEYS-1:0] KEYPAD_EVENT_O // Keypad events, registered
);

  localparam int NP = `GP_NUM_PINS;
  localparam int NK = `GP_NUM_KEYS;

  ////////////////////////////////////////////////////////////////////////
  // Register storage, sized to the documented fields
  logic [4:0] a_data_r, a_data_nxt; // Port A latch
  logic [3:0] a_pull_r, a_pull_nxt; // Port A pulls
  logic [3:0] a_dir_r, a_dir_nxt; // Port A directions, pin four fixed
  logic [1:0] b_data_r, b_data_nxt; // Port B latch
  logic [1:0] b_pull_r, b_pull_nxt; // Port B pulls
  logic [1:0] b_dir_r, b_dir_nxt; // Port B directions
  logic [NP-1:0] dig_en_r, dig_en_nxt; // Shared digital enables
  logic [NP-1:0] ana_en_r, ana_en_nxt; // Analog enables
  logic [7:0] key_cfg_r, key_cfg_nxt; // Pin enables low, edge select high
  logic [7:0] key_mode_r, key_mode_nxt; // Edge enables low, level enables high
  logic irq_en_r, irq_en_nxt; // Pin zero interrupt enable
  logic irq_r, irq_nxt; // Interrupt request flop
  logic strap_pend_r, strap_pend_nxt; // Debug strap not yet sampled
  logic dbg_mode_r, dbg_mode_nxt; // Debug owns pin four
  gp_port_pkg::bus_state_t state_r, state_nxt; // Bus answer phase
  logic [31:0] rdata_r, rdata_nxt; // Read data
  logic req; // Bus request present
  logic aligned; // Word-aligned address
  logic [3:0] idx; // Register index
  logic wr_go; // Write takes effect this edge
  logic [7:0] rd_byte; // Selected register value

  ////////////////////////////////////////////////////////////////////////
  // Effective per-pin vectors
  logic [NP-1:0] dir_eff; // Direction as seen by the cells
  logic [NP-1:0] data_eff; // Latch values
  logic [NP-1:0] pull_eff; // Pull enables
  logic [NP-1:0] dig_eff; // Digital ownership incl. debug
  logic [NP-1:0] per_out; // Peripheral values incl. debug
  logic [NP-1:0] per_oe; // Peripheral enables incl. debug
  logic [NP-1:0] pd_sel; // Keypad pull-down requests
  logic [NP-1:0] rd_bits; // Read-back bits
  logic stop_any; // Any stop mode

  always_comb
  begin
    // Pin four is output-only, but stays off until the debug strap is taken
    dir_eff = {b_dir_r, ~strap_pend_r, a_dir_r};
    data_eff = {b_data_r, a_data_r};
    pull_eff = {b_pull_r, 1'b0, a_pull_r};
    dig_eff = dig_en_r;
    per_out = PERIPH_OUT_I;
    per_oe = PERIPH_OE_I;
    dig_eff[`GP_PIN_DBG] = dig_en_r[`GP_PIN_DBG] | dbg_mode_r;
    per_out[`GP_PIN_DBG] = dbg_mode_r ? DBG_OUT_I : PERIPH_OUT_I[`GP_PIN_DBG];
    per_oe[`GP_PIN_DBG] = dbg_mode_r ? DBG_OE_I : PERIPH_OE_I[`GP_PIN_DBG];
    pd_sel = {{(NP-NK){1'b0}}, key_cfg_r[3:0] & key_cfg_r[7:4]};
    stop_any = DEEP_STOP_I | RETAIN_STOP_I;
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-pin cells and keypad senses
  for (genvar gi = 0; gi < NP; gi++)
  begin : g_pin
    gp_port_pkg::pin_ctrl_t ctrl; // Bundled controls
    gp_port_pkg::pin_pad_t pad; // Bundled pad outputs
    assign ctrl = '{dir: dir_eff[gi], data: data_eff[gi], pull: pull_eff[gi],
                    dig: dig_eff[gi], ana: ana_en_r[gi], pd_sel: pd_sel[gi],
                    off: DEEP_STOP_I};
    gp_pin_cell u_cell
    (
      .ctrl_i(ctrl),
      .per_out_i(per_out[gi]),
      .per_oe_i(per_oe[gi]),
      .pin_i(PIN_I[gi]),
      .pad_o(pad),
      .rd_o(rd_bits[gi])
    );
    assign PIN_O[gi] = pad.out;
    assign PIN_OE_O[gi] = pad.oe;
    assign PULLUP_O[gi] = pad.pu;
    assign PULLDN_O[gi] = pad.pd;
    assign INBUF_EN_O[gi] = pad.inbuf;
    assign PERIPH_IN_O[gi] = PIN_I[gi] & pad.inbuf;
    if (gi < NK)
    begin : g_key
      gp_key_sense u_key
      (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .ce_i(CE_I),
        .pin_i(PIN_I[gi] & pad.inbuf),
        .en_i(key_cfg_r[gi]),
        .rise_i(key_cfg_r[gi+4]),
        .edge_en_i(key_mode_r[gi]),
        .level_en_i(key_mode_r[gi+4]),
        .stop_i(stop_any),
        .event_o(KEYPAD_EVENT_O[gi])
      );
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; one wait cycle, then the answer
  always_comb
  begin
    req = AVS_READ_I | AVS_WRITE_I;
    idx = AVS_ADDRESS_I[5:2];
    aligned = (AVS_ADDRESS_I[1:0] == 2'h0);
    AVS_WAITREQUEST_O = req & ~((state_r == gp_port_pkg::BUS_ANSWER) & CE_I);
    wr_go = (state_r == gp_port_pkg::BUS_ANSWER) & AVS_WRITE_I & AVS_BYTEENABLE_I[0]
            & aligned;
    // Unmapped or misaligned reads answer zero
    if (!aligned)
    begin
      rd_byte = 8'h00;
    end
    else if (idx == `GP_IDX_A_DATA)
    begin
      rd_byte = {3'h0, rd_bits[4:0]};
    end
    else if (idx == `GP_IDX_A_PULL)
    begin
      rd_byte = {4'h0, a_pull_r};
    end
    else if (idx == `GP_IDX_A_DIR)
    begin
      rd_byte = {4'h1, a_dir_r};
    end
    else if (idx == `GP_IDX_B_DATA)
    begin
      rd_byte = {6'h00, rd_bits[6:5]};
    end
    else if (idx == `GP_IDX_B_PULL)
    begin
      rd_byte = {6'h00, b_pull_r};
    end
    else if (idx == `GP_IDX_B_DIR)
    begin
      rd_byte = {6'h00, b_dir_r};
    end
    else if (idx == `GP_IDX_DIG_EN)
    begin
      rd_byte = {1'b0, dig_en_r};
    end
    else if (idx == `GP_IDX_ANA_EN)
    begin
      rd_byte = {1'b0, ana_en_r};
    end
    else if (idx == `GP_IDX_KEY_CFG)
    begin
      rd_byte = key_cfg_r;
    end
    else if (idx == `GP_IDX_KEY_MODE)
    begin
      rd_byte = key_mode_r;
    end
    else if (idx == `GP_IDX_IRQ_CFG)
    begin
      rd_byte = {6'h00, dbg_mode_r, irq_en_r};
    end
    else
    begin
      rd_byte = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next register values
  always_comb
  begin
    a_data_nxt = a_data_r;
    a_pull_nxt = a_pull_r;
    a_dir_nxt = a_dir_r;
    b_data_nxt = b_data_r;
    b_pull_nxt = b_pull_r;
    b_dir_nxt = b_dir_r;
    dig_en_nxt = dig_en_r;
    ana_en_nxt = ana_en_r;
    key_cfg_nxt = key_cfg_r;
    key_mode_nxt = key_mode_r;
    irq_en_nxt = irq_en_r;
    state_nxt = state_r;
    rdata_nxt = rdata_r;
    strap_pend_nxt = 1'b0;
    dbg_mode_nxt = dbg_mode_r;
    // Strap sampled once, first enabled edge after reset release
    if (strap_pend_r)
    begin
      dbg_mode_nxt = ~PIN_I[`GP_PIN_DBG];
    end
    // Bus phase
    case (state_r)
      gp_port_pkg::BUS_IDLE:
      begin
        if (req)
        begin
          state_nxt = gp_port_pkg::BUS_ANSWER;
          rdata_nxt = {24'h00_0000, rd_byte};
        end
      end
      default:
      begin
        state_nxt = gp_port_pkg::BUS_IDLE;
      end
    endcase
    // Register writes; reserved bits are dropped
    if (wr_go)
    begin
      if (idx == `GP_IDX_A_DATA)
      begin
        a_data_nxt = AVS_WRITEDATA_I[4:0];
      end
      else if (idx == `GP_IDX_A_PULL)
      begin
        a_pull_nxt = AVS_WRITEDATA_I[3:0];
      end
      else if (idx == `GP_IDX_A_DIR)
      begin
        a_dir_nxt = AVS_WRITEDATA_I[3:0];
      end
      else if (idx == `GP_IDX_B_DATA)
      begin
        b_data_nxt = AVS_WRITEDATA_I[1:0];
      end
      else if (idx == `GP_IDX_B_PULL)
      begin
        b_pull_nxt = AVS_WRITEDATA_I[1:0];
      end
      else if (idx == `GP_IDX_B_DIR)
      begin
        b_dir_nxt = AVS_WRITEDATA_I[1:0];
      end
      else if (idx == `GP_IDX_DIG_EN)
      begin
        dig_en_nxt = AVS_WRITEDATA_I[6:0];
      end
      else if (idx == `GP_IDX_ANA_EN)
      begin
        ana_en_nxt = AVS_WRITEDATA_I[6:0];
      end
      else if (idx == `GP_IDX_KEY_CFG)
      begin
        key_cfg_nxt = AVS_WRITEDATA_I[7:0];
      end
      else if (idx == `GP_IDX_KEY_MODE)
      begin
        key_mode_nxt = AVS_WRITEDATA_I[7:0];
      end
      else if (idx == `GP_IDX_IRQ_CFG)
      begin
        irq_en_nxt = AVS_WRITEDATA_I[0];
      end
    end
    // Deep stop powers the registers down; retention stop leaves them
    if (DEEP_STOP_I)
    begin
      a_data_nxt = `GP_A_DATA_RST;
      a_pull_nxt = `GP_A_PULL_RST;
      a_dir_nxt = `GP_A_DIR_RST;
      b_data_nxt = `GP_B_RST;
      b_pull_nxt = `GP_B_RST;
      b_dir_nxt = `GP_B_RST;
      dig_en_nxt = `GP_FUNC_EN_RST;
      ana_en_nxt = `GP_FUNC_EN_RST;
      key_cfg_nxt = `GP_KEY_RST;
      key_mode_nxt = `GP_KEY_RST;
      irq_en_nxt = `GP_IRQ_RST;
    end
    // Low level on pin zero requests the interrupt and retention stop exit
    irq_nxt = irq_en_r & ~PIN_I[`GP_PIN_IRQ] & INBUF_EN_O[`GP_PIN_IRQ];
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; reset leaves every shared function off
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      a_data_r <= `GP_A_DATA_RST;
      a_pull_r <= `GP_A_PULL_RST;
      a_dir_r <= `GP_A_DIR_RST;
      b_data_r <= `GP_B_RST;
      b_pull_r <= `GP_B_RST;
      b_dir_r <= `GP_B_RST;
      dig_en_r <= `GP_FUNC_EN_RST;
      ana_en_r <= `GP_FUNC_EN_RST;
      key_cfg_r <= `GP_KEY_RST;
      key_mode_r <= `GP_KEY_RST;
      irq_en_r <= `GP_IRQ_RST;
      irq_r <= 1'b0;
      strap_pend_r <= 1'b1;
      dbg_mode_r <= 1'b0;
      state_r <= gp_port_pkg::BUS_IDLE;
      rdata_r <= 32'h0000_0000;
    end
    else if (CE_I)
    begin
      // Retention stop needs nothing: the flops simply hold
      a_data_r <= a_data_nxt;
      a_pull_r <= a_pull_nxt;
      a_dir_r <= a_dir_nxt;
      b_data_r <= b_data_nxt;
      b_pull_r <= b_pull_nxt;
      b_dir_r <= b_dir_nxt;
      dig_en_r <= dig_en_nxt;
      ana_en_r <= ana_en_nxt;
      key_cfg_r <= key_cfg_nxt;
      key_mode_r <= key_mode_nxt;
      irq_en_r <= irq_en_nxt;
      irq_r <= irq_nxt;
      strap_pend_r <= strap_pend_nxt;
      dbg_mode_r <= dbg_mode_nxt;
      state_r <= state_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign AVS_READDATA_O = rdata_r;
  assign IRQ_REQ_O = irq_r;
  assign DBG_MODE_O = dbg_mode_r;
  assign DBG_IN_O = PIN_I[`GP_PIN_DBG] & INBUF_EN_O[`GP_PIN_DBG];

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_READ_PIN: assert property ((rd_bits & ~dir_eff & INBUF_EN_O) == (PIN_I & ~dir_eff & INBUF_EN_O)) else $error("input read differs from pin");
  AST_READ_LATCH: assert property ((rd_bits & dir_eff) == (data_eff & dir_eff)) else $error("output read differs from latch");
  AST_ANA_QUIET: assert property (((INBUF_EN_O | PIN_OE_O | rd_bits & ~dir_eff) & ana_en_r) == '0) else $error("analog pin not quiet");
  AST_PULL_GATE: assert property (((PULLUP_O | PULLDN_O) & (PIN_OE_O | ana_en_r | dir_eff)) == '0) else $error("pull on an output");
  AST_PULLDN: assert property (PULLDN_O == (pull_eff & ~dir_eff & ~ana_en_r & ~(dig_eff & per_oe) & pd_sel & {NP{~DEEP_STOP_I}})) else $error("pull-down select wrong");
  AST_STRAP: assert property (strap_pend_r && CE_I |=> dbg_mode_r == !$past(PIN_I[4])) else $error("debug strap not caught");
  AST_DEEP: assert property (DEEP_STOP_I && CE_I |=> a_data_r == 5'h00 && dig_en_r == 7'h00 && a_dir_r == 4'h0) else $error("deep stop kept state");
  AST_WRITE: assert property (wr_go && CE_I && idx == 4'h0 && !DEEP_STOP_I |=> a_data_r == $past(AVS_WRITEDATA_I[4:0])) else $error("data write lost");
  AST_ANSWER: assert property (req && CE_I && state_r == gp_port_pkg::BUS_IDLE ##1 CE_I |-> !AVS_WAITREQUEST_O) else $error("bus answer late");
  AST_RSVD: assert property (AVS_READDATA_O[31:8] == 24'h00_0000) else $error("upper read bits set");

  COV_READ_A: cover property (AVS_READ_I && !AVS_WAITREQUEST_O && idx == 4'h0);
  COV_WRITE: cover property (wr_go && CE_I);
  COV_DEBUG: cover property (dbg_mode_r);
  COV_KEY: cover property (KEYPAD_EVENT_O != 4'h0);

endmodule

`default_nettype wire

// ---- gp_port_params.svh ----
/*
  Constants of the general purpose pin port: register indices, reset
  values, field positions and widths.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef GP_PORT_PARAMS_SVH
`define GP_PORT_PARAMS_SVH

// Register indices; byte address is four times the index
`define GP_IDX_A_DATA 4'h0
`define GP_IDX_A_PULL 4'h1
`define GP_IDX_A_DIR 4'h3
`define GP_IDX_B_DATA 4'h4
`define GP_IDX_B_PULL 4'h5
`define GP_IDX_B_DIR 4'h7
`define GP_IDX_DIG_EN 4'h8
`define GP_IDX_ANA_EN 4'h9
`define GP_IDX_KEY_CFG 4'hA
`define GP_IDX_KEY_MODE 4'hB
`define GP_IDX_IRQ_CFG 4'hC

// Reset values
`define GP_A_DATA_RST 5'h00
`define GP_A_PULL_RST 4'h0
`define GP_A_DIR_RST 4'h0
`define GP_B_RST 2'h0
`define GP_FUNC_EN_RST 7'h00
`define GP_KEY_RST 8'h00
`define GP_IRQ_RST 1'b0

// Pin positions
`define GP_PIN_IRQ 0
`define GP_PIN_DBG 4
`define GP_NUM_PINS 7
`define GP_NUM_KEYS 4

`endif

// ---- gp_port_pkg.sv ----
/*
  Types of the general purpose pin port: per-pin control and pad bundles,
  and the bus answer states.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package gp_port_pkg;

  // Controls that steer one pin
  typedef struct packed {
    logic dir;   // Output driver requested by software
    logic data;  // Output latch
    logic pull;  // Pull enable
    logic dig;   // Shared digital function owns the pin
    logic ana;   // Analog function owns the pin
    logic pd_sel; // Keypad asks for a pull-down instead
    logic off;   // Deep stop: everything off
  } pin_ctrl_t;

  // What one pin drives toward its pad
  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
    logic pd;
    logic inbuf;
  } pin_pad_t;

  // Register bus answer phases
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

endpackage

`default_nettype wire

// ---- gp_port_tb.sv ----
/*
  Self-checking bench of the pin port: bus tasks, a read monitor fed by a
  queue of expected values, and pad checks.
  Assumes the board model and the design files are compiled first.
*/
`include "gp_port_params.svh"
`default_nettype none

module general_purpose_pin_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, rd_r = 1'b0, wr_r = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic wait_o, dbg_mode, irq;
  logic [6:0] pin, pout, poe, pu, pd, inbuf, ext_en = 7'h7F, ext_val = 7'h10;
  logic [6:0] per_out = 7'h00, per_oe = 7'h00;
  logic deep = 1'b0, retain = 1'b0;
  logic ce = 1'b1; // Clock enable, dropped once inside a read
  logic [3:0] kev; // Keypad events
  logic [31:0] expq[$], r, e; // Expected read data, oldest first
  int n_errors = 0, compares = 0, seed = 32'h28ae_45e4;

  ////////////////////////////////////////////////////////////////////
  // Clock at 8 ns
  initial
  begin
    forever #4 clk = ~clk;
  end

  gp_port u_dut (.CLK_I(clk), .CE_I(ce), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd_r), .AVS_WRITE_I(wr_r), .AVS_WRITEDATA_I(wdat),
    .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_o),
    .PIN_I(pin), .PIN_O(pout), .PIN_OE_O(poe), .PULLUP_O(pu), .PULLDN_O(pd),
    .INBUF_EN_O(inbuf), .PERIPH_OUT_I(per_out), .PERIPH_OE_I(per_oe),
    .PERIPH_IN_O(), .DEEP_STOP_I(deep), .RETAIN_STOP_I(retain), .DBG_OUT_I(1'b0),
    .DBG_OE_I(1'b0), .DBG_IN_O(), .DBG_MODE_O(dbg_mode), .IRQ_REQ_O(irq),
    .KEYPAD_EVENT_O(kev));
  gp_board u_board (.clk_i(clk), .out_i(pout), .oe_i(poe), .pu_i(pu), .pd_i(pd),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin));

  ////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    addr <= {idx, 2'b00};
    wr_r <= w;
    rd_r <= ~w;
    wdat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      n_errors++;
      print_verdict();
    end
    wr_r <= 1'b0;
    rd_r <= 1'b0;
    // Let an edge pass so the next call never re-raises in this step
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [7:0] x);
    expq.push_back({24'h00_0000, x});
    bus(1'b0, idx, 8'h00);
  endtask

  // Read monitor: read data are taken at the accepting edge
  always @(posedge clk)
  begin
    if (rd_r && wait_o === 1'b0 && expq.size() > 0) chk(rdat, expq.pop_front());
  end

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`GP_IDX_A_DATA, 8'h00);
    @(negedge clk);
    chk(poe, 7'h10);
    chk(dbg_mode, 1'b0);
    chk(inbuf, 7'h7F);
    rd(4'h2, 8'h00);
    // Data loaded before turning drivers on
    bus(1'b1, `GP_IDX_A_DATA, 8'h15);
    bus(1'b1, `GP_IDX_A_DIR, 8'h0F);
    rd(`GP_IDX_A_DATA, 8'h15);
    @(negedge clk);
    chk(poe[3:0], 4'hF);
    chk(pout[3:0], 4'h5);
    bus(1'b1, `GP_IDX_A_DIR, 8'h00);
    r = $random(seed);
    ext_val <= {3'b001, r[3:0]};
    rd(`GP_IDX_A_DATA, {4'h1, r[3:0]});
    // Board lets go; pulls decide the level
    ext_en <= 7'h00;
    bus(1'b1, `GP_IDX_A_PULL, 8'h0F);
    bus(1'b1, `GP_IDX_KEY_CFG, 8'h5F);
    // Level sensing only; pulls keep every keypad pin inactive
    bus(1'b1, `GP_IDX_KEY_MODE, 8'hF0);
    @(negedge clk);
    chk(kev, 4'h0);
    chk(pu[3:0], 4'hA);
    chk(pd[3:0], 4'h5);
    rd(`GP_IDX_A_DATA, 8'h1A);
    bus(1'b1, `GP_IDX_A_DIR, 8'h02);
    @(negedge clk);
    chk(pu[3:0], 4'h8);
    chk(kev, 4'h2);
    bus(1'b1, `GP_IDX_A_DIR, 8'h00);
    // Digital on pins 1,2; analog on pins 0,1
    per_oe <= 7'h7F;
    per_out <= r[10:4];
    bus(1'b1, `GP_IDX_DIG_EN, 8'h06);
    bus(1'b1, `GP_IDX_ANA_EN, 8'h03);
    @(negedge clk);
    chk(poe[2:0], 3'b100);
    chk(pout[2], r[6]);
    chk(inbuf[1:0], 2'b00);
    chk(pu[2:0], 3'b000);
    e = {27'h0, 2'b11, r[6], 2'b00};
    rd(`GP_IDX_A_DATA, e[7:0]);
    retain <= 1'b1;
    repeat (3) @(posedge clk);
    // Clock enable drops for one cycle inside the read: one more wait state
    fork
      rd(`GP_IDX_A_DATA, e[7:0]);
      begin
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        ce <= 1'b1;
      end
    join
    @(negedge clk);
    chk(kev, {~r[6], 2'b11});
    retain <= 1'b0;
    deep <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({poe, pu, inbuf}, 0);
    @(posedge clk);
    deep <= 1'b0;
    per_oe <= 7'h00;
    rd(`GP_IDX_A_DIR, 8'h10);
    rd(`GP_IDX_ANA_EN, 8'h00);
    // Pin zero held low with request enabled
    ext_en <= 7'h7F;
    ext_val <= 7'h10;
    bus(1'b1, `GP_IDX_IRQ_CFG, 8'h01);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(irq, 1'b1);
    // Pin four strapped low across reset release
    @(posedge clk);
    rst <= 1'b1;
    ext_val <= 7'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(dbg_mode, 1'b1);
    print_verdict();
  end
endmodule

`default_nettype wire
